/* common/sldrv_defines.svh */
// Shared constants for the serial latched sink driver and its host.
`ifndef SLDRV_DEFINES_SVH
`define SLDRV_DEFINES_SVH
`define SLDRV_WIDTH          8
`define SLDRV_CLK_SYS_PS     4000
`define SLDRV_STRB_SETUP_NS  100
`define SLDRV_STRB_SETUP_CYC ((`SLDRV_STRB_SETUP_NS * 1000 + `SLDRV_CLK_SYS_PS - 1) / `SLDRV_CLK_SYS_PS)
`define SLDRV_MAX_RATE_KHZ   10000
`define SLDRV_SYS_RATE_KHZ   250000
`define SLDRV_HALF_CYC       ((`SLDRV_SYS_RATE_KHZ + 2 * `SLDRV_MAX_RATE_KHZ - 1) / (2 * `SLDRV_MAX_RATE_KHZ))
`define SLDRV_RESET_BYTE     8'h00
`define SLDRV_RESET_BIT      1'b0
`endif

/* common/sldrv_if.sv */
// Pin-level link between host controller and sink driver.
`timescale 1ns/10ps
`default_nettype none
interface sldrv_if;
  logic shift_clk;
  logic ser_data_in;
  logic ser_data_out;
  logic latch_load_strobe;
  logic out_disable;
  logic [7:0] sink_on;
  modport device (input shift_clk, input ser_data_in, input latch_load_strobe, input out_disable,
                  output ser_data_out, output sink_on);
  modport host (output shift_clk, output ser_data_in, output latch_load_strobe, output out_disable,
                input ser_data_out, input sink_on);
endinterface
`default_nettype wire

/* common/sldrv_pkg.sv */
// Types shared by the sink driver and its host.
package sldrv_pkg;
  typedef logic [7:0] sldrv_byte_t;
  typedef enum logic [2:0] {SLDRV_IDLE, SLDRV_LOW, SLDRV_HIGH, SLDRV_WAIT, SLDRV_STRB} sldrv_host_state_t;
endpackage

/* hdl/sldrv_device.sv */
// Device end: shift register, clocked latches and gated sink outputs.
`timescale 1ns/10ps
`default_nettype none
`include "sldrv_defines.svh"

// ==========================================================
// Two-flop synchroniser for one pin of the link.
module sldrv_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      sync_o
);
  import sldrv_pkg::*;
  // The first flop may go metastable, so only the second one is ever read.
  logic meta_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RESET_VAL;
      sync_o   <= RESET_VAL;
    end else begin
      meta_reg <= pin_i;
      sync_o   <= meta_reg;
    end
  end
endmodule // sldrv_sync

// ==========================================================
// One output slice: a clocked latch on one register stage and the sink it drives.
module sldrv_slice (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic stage_i,
  input  wire logic load_i,
  input  wire logic off_i,
  output logic      latch_o,
  output logic      sink_o
);
  import sldrv_pkg::*;
  // The latch is clocked, so it trails a true transparent latch by a cycle while loading.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_o <= `SLDRV_RESET_BIT;
    end else if (load_i) begin
      latch_o <= stage_i;
    end
  end
  // Disable only gates the sink; it never reaches the latch.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sink_o <= 1'b0;
    end else begin
      sink_o <= off_i ? 1'b0 : latch_o;
    end
  end
endmodule // sldrv_slice

// What this block does
// - Eight stages, eight latches, eight sink outputs.
// - Rising shift clock loads serial input stage.
// - Each rising edge moves data toward output.
// - Strobe high makes latches follow the register.
// - Disable high turns every sink off.
// - Disable never alters register or latches.
// - Disable low: outputs follow their latches.
// - Host keeps disable high when strobe tied high; here strobe only pulses, with shift clock low, and disable follows disable_i.
// - Reset clears register and latches low.
// - Host waits 100 ns before raising strobe.
// - Host shift rate at most 10 MHz.
// - Devices chain serial output to serial input.
module sldrv_device (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  sldrv_if.device            link,
  output logic [7:0]         latch_view_o
);
  import sldrv_pkg::*;
  // ==========================================================
  // Input synchronisers
  // Every link pin follows the host's timing, so each one passes two flops first.
  logic clk_sync;
  logic din_sync;
  logic stb_sync;
  logic dis_sync;
  sldrv_sync #(
    .RESET_VAL(1'b0)
  ) i_clk_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .pin_i    (link.shift_clk),
    .sync_o   (clk_sync)
  );
  sldrv_sync #(
    .RESET_VAL(1'b0)
  ) i_din_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .pin_i    (link.ser_data_in),
    .sync_o   (din_sync)
  );
  sldrv_sync #(
    .RESET_VAL(1'b0)
  ) i_stb_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .pin_i    (link.latch_load_strobe),
    .sync_o   (stb_sync)
  );
  // Disable is taken as high out of reset so no sink can turn on before the pin is seen.
  sldrv_sync #(
    .RESET_VAL(1'b1)
  ) i_dis_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .pin_i    (link.out_disable),
    .sync_o   (dis_sync)
  );
  // ==========================================================
  // Shift clock edge
  // Data is delayed as much as the clock so setup at the pins holds here too.
  logic clk_prev_reg;
  logic rise;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= clk_sync;
    end
  end
  assign rise = clk_sync & ~clk_prev_reg;
  // ==========================================================
  // Shift register
  sldrv_byte_t shift_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= `SLDRV_RESET_BYTE;
    end else if (rise) begin
      shift_reg <= {shift_reg[6:0], din_sync};
    end
  end
  // ==========================================================
  // Output slices
  // Each stage owns one latch and one sink, so register bit k drives sink k.
  sldrv_byte_t latch_bits;
  sldrv_byte_t sink_bits;
  sldrv_slice i_slice_0 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[0]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[0]),
    .sink_o   (sink_bits[0])
  );
  sldrv_slice i_slice_1 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[1]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[1]),
    .sink_o   (sink_bits[1])
  );
  sldrv_slice i_slice_2 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[2]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[2]),
    .sink_o   (sink_bits[2])
  );
  sldrv_slice i_slice_3 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[3]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[3]),
    .sink_o   (sink_bits[3])
  );
  sldrv_slice i_slice_4 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[4]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[4]),
    .sink_o   (sink_bits[4])
  );
  sldrv_slice i_slice_5 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[5]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[5]),
    .sink_o   (sink_bits[5])
  );
  sldrv_slice i_slice_6 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[6]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[6]),
    .sink_o   (sink_bits[6])
  );
  sldrv_slice i_slice_7 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i  (rst_n_i),
    .stage_i  (shift_reg[7]),
    .load_i   (stb_sync),
    .off_i    (dis_sync),
    .latch_o  (latch_bits[7]),
    .sink_o   (sink_bits[7])
  );
  // ==========================================================
  // Outputs
  assign link.sink_on      = sink_bits;
  assign link.ser_data_out = shift_reg[7];
  assign latch_view_o      = latch_bits;
endmodule // sldrv_device
`default_nettype wire

/* hdl/sldrv_host.sv */
// Host end: shifts a byte out, waits, then pulses the strobe.
`timescale 1ns/10ps
`default_nettype none
`include "sldrv_defines.svh"
module sldrv_host (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  sldrv_if.host                     link,
  input  wire logic                 send_valid_i,
  input  wire sldrv_pkg::sldrv_byte_t send_data_i,
  output logic                      send_ready_o,
  input  wire logic                 disable_i,
  output logic                      chain_out_o
);
  import sldrv_pkg::*;
  localparam int HALF = `SLDRV_HALF_CYC;
  localparam int SETUP = `SLDRV_STRB_SETUP_CYC;
  // ==========================================================
  // Sequencer
  sldrv_host_state_t state_reg;
  sldrv_byte_t       data_reg;
  logic [3:0]        bit_reg;
  logic [7:0]        cnt_reg;
  logic              sclk_reg;
  logic              strb_reg;
  logic              dis_reg;
  logic [1:0]        sdo_sync_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SLDRV_IDLE;
      data_reg  <= 8'h00;
      bit_reg   <= 4'h0;
      cnt_reg   <= 8'h00;
      sclk_reg  <= 1'b0;
      strb_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        SLDRV_IDLE: begin
          strb_reg <= 1'b0;
          if (send_valid_i) begin
            data_reg  <= send_data_i;
            bit_reg   <= 4'h0;
            cnt_reg   <= 8'h00;
            state_reg <= SLDRV_LOW;
          end
        end
        SLDRV_LOW: begin
          // Half periods of at least 50 ns keep the rate at or under 10 MHz.
          if (cnt_reg == 8'(HALF - 1)) begin
            cnt_reg   <= 8'h00;
            sclk_reg  <= 1'b1;
            state_reg <= SLDRV_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        SLDRV_HIGH: begin
          if (cnt_reg == 8'(HALF - 1)) begin
            cnt_reg  <= 8'h00;
            sclk_reg <= 1'b0;
            data_reg <= {data_reg[6:0], 1'b0};
            bit_reg  <= bit_reg + 4'h1;
            state_reg <= (bit_reg == 4'h7) ? SLDRV_WAIT : SLDRV_LOW;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        SLDRV_WAIT: begin
          // Counted from the last rising edge's fall; the high half already adds margin.
          if (cnt_reg == 8'(SETUP - 1)) begin
            cnt_reg   <= 8'h00;
            strb_reg  <= 1'b1;
            state_reg <= SLDRV_STRB;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        SLDRV_STRB: begin
          if (cnt_reg == 8'(HALF - 1)) begin
            strb_reg  <= 1'b0;
            state_reg <= SLDRV_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        default: state_reg <= SLDRV_IDLE;
      endcase
    end
  end
  // Every pin starts low so the driver's power-on clear holds; its latches are clear, so sinks stay off.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dis_reg      <= 1'b0;
      sdo_sync_reg <= 2'h0;
    end else begin
      dis_reg      <= disable_i;
      sdo_sync_reg <= {sdo_sync_reg[0], link.ser_data_out};
    end
  end
  assign send_ready_o           = (state_reg == SLDRV_IDLE);
  assign link.shift_clk         = sclk_reg;
  assign link.ser_data_in       = data_reg[7];
  assign link.latch_load_strobe = strb_reg;
  assign link.out_disable       = dis_reg;
  assign chain_out_o            = sdo_sync_reg[1];
endmodule // sldrv_host
`default_nettype wire

/* verif/sldrv_properties.sv */
// Concurrent checks on the link between host and sink driver.
`timescale 1ns/10ps
`default_nettype none
module sldrv_properties (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       shift_clk,
  input wire logic       ser_data_in,
  input wire logic       ser_data_out,
  input wire logic       latch_load_strobe,
  input wire logic       out_disable,
  input wire logic [7:0] sink_on
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Shadow of the shift register, and cycles since the shift clock last rose.
  logic [7:0] shadow;
  logic [7:0] idle_cnt;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) shadow <= 8'h00;
    else if ($rose(shift_clk)) shadow <= {shadow[6:0], ser_data_in};
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) idle_cnt <= 8'hFF;
    else idle_cnt <= $rose(shift_clk) ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hFF};
  end
  // ==========================================
  // Assertions.
  a_reset_clear: assert property (!$past(rst_n_i) |-> sink_on == 8'h00 && !ser_data_out)
    else $error("outputs not clear after reset");
  a_shift_sample: assert property ($rose(shift_clk) |-> ##6 ser_data_out == shadow[7])
    else $error("serial output differs from shifted data");
  a_sdo_moves: assert property ($changed(ser_data_out) |-> $past(shift_clk, 3) && !$past(shift_clk, 6))
    else $error("serial output changed without a shift");
  a_strobe_load: assert property ($fell(latch_load_strobe) && !out_disable |-> ##6 sink_on == shadow)
    else $error("sinks differ from register after strobe");
  a_latch_hold: assert property ((!out_disable && !latch_load_strobe)[*8] |-> $stable(sink_on))
    else $error("sinks moved while strobe low");
  a_disable_off: assert property (out_disable[*5] |-> sink_on == 8'h00)
    else $error("sink on while disabled");
  a_strobe_setup: assert property ($rose(latch_load_strobe) |-> idle_cnt >= 8'h18)
    else $error("strobe too soon after shift clock");
  a_clk_rate: assert property ($rose(shift_clk) |-> shift_clk[*8])
    else $error("shift clock high too short");
  a_shift_period: assert property ($rose(shift_clk) |-> idle_cnt >= 8'h18)
    else $error("shift clock period too short");
  a_shift_masked: assert property (latch_load_strobe |-> !shift_clk || out_disable)
    else $error("shift clock ran with strobe high and sinks enabled");
  c_strobe: cover property ($rose(latch_load_strobe));
  c_disable: cover property ($rose(out_disable));
  c_shift: cover property ($rose(shift_clk) && ser_data_in);
endmodule // sldrv_properties
`default_nettype wire

/* verif/tb_top.sv */
// Bench joining host and sink driver through the link.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sldrv_pkg::*;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        send_valid_i;
  sldrv_byte_t send_data_i;
  logic        send_ready_o;
  logic        disable_i;
  logic        chain_out_o;
  logic [7:0]  latch_view_o;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  sldrv_byte_t tbl[3] = '{8'h01, 8'h80, 8'hFF};
  sldrv_if link();
  sldrv_host i_sldrv_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link), .send_valid_i(send_valid_i),
    .send_data_i(send_data_i), .send_ready_o(send_ready_o), .disable_i(disable_i), .chain_out_o(chain_out_o));
  sldrv_device i_sldrv_device (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link), .latch_view_o(latch_view_o));
  sldrv_properties i_sldrv_properties (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .shift_clk(link.shift_clk),
    .ser_data_in(link.ser_data_in), .ser_data_out(link.ser_data_out), .latch_load_strobe(link.latch_load_strobe),
    .out_disable(link.out_disable), .sink_on(link.sink_on));
  always #2 clk_sys_i = ~clk_sys_i;
  task automatic stop_test;
    $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hung handshake ends here rather than stalling the run.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input sldrv_byte_t b);
    do @(negedge clk_sys_i); while (send_ready_o !== 1'b1);
    @(posedge clk_sys_i);
    send_valid_i <= 1'b1;
    send_data_i <= b;
    @(posedge clk_sys_i);
    send_valid_i <= 1'b0;
  endtask
  task automatic settle;
    do @(negedge clk_sys_i); while (send_ready_o !== 1'b1);
    repeat (8) @(negedge clk_sys_i);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    rst_n_i = 1'b0;
    send_valid_i = 1'b0;
    send_data_i = 8'h00;
    disable_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    check(link.sink_on, 8'h00);
    check(latch_view_o, 8'h00);
    @(posedge clk_sys_i);
    disable_i <= 1'b0;
    send(8'hA5);
    settle();
    check(latch_view_o, 8'hA5);
    check(link.sink_on, 8'hA5);
    check({7'h00, link.ser_data_out}, 8'h01);
    send(8'h3C);
    repeat (100) @(negedge clk_sys_i);
    check(latch_view_o, 8'hA5);
    settle();
    check(latch_view_o, 8'h3C);
    @(posedge clk_sys_i);
    disable_i <= 1'b1;
    repeat (10) @(negedge clk_sys_i);
    check(link.sink_on, 8'h00);
    check(latch_view_o, 8'h3C);
    @(posedge clk_sys_i);
    disable_i <= 1'b0;
    repeat (10) @(negedge clk_sys_i);
    check(link.sink_on, 8'h3C);
    foreach (tbl[i]) begin
      send(tbl[i]);
      @(negedge clk_sys_i);
      check({6'h00, send_ready_o, link.shift_clk}, 8'h00);
      settle();
      check(link.sink_on, tbl[i]);
      check({7'h00, chain_out_o}, {7'h00, tbl[i][7]});
    end
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    check(link.sink_on, 8'h00);
    check(latch_view_o, 8'h00);
    check({7'h00, link.ser_data_out}, 8'h00);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
